// ==== verilog/plc_defines.svh ====
// Register offsets, reset values and field widths of the custom logic cell
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

`define PLC_ADDR_W 8
`define PLC_DATA_W 32

`define PLC_OFS_CELL_SELECT 8'h00
`define PLC_OFS_TABLE_SELECT 8'h04
`define PLC_OFS_INPUT_SELECT 8'h08
`define PLC_OFS_INPUT_SOURCE 8'h0c
`define PLC_OFS_INPUT_QUALIFIER 8'h10
`define PLC_OFS_TABLE_WORD 8'h14
`define PLC_OFS_ROW_INDEX 8'h18
`define PLC_OFS_ROW_BIT 8'h1c
`define PLC_OFS_STATUS 8'h20

`define PLC_CELLS 2
`define PLC_TABLES 2
`define PLC_TABLE_INPUTS 3
`define PLC_TABLE_ROWS 8
`define PLC_SRC_W 5
`define PLC_QUAL_W 3
`define PLC_SRC_COUNT 19
`define PLC_QUAL_COUNT 5

`define PLC_TABLE_VALUE 1'h0
`define PLC_TABLE_ENABLE 1'h1

`define PLC_RST_TABLE 8'h00
`define PLC_RST_OUT 1'h0
`define PLC_RST_SEL 1'h0
`define PLC_RST_INPUT_SEL 2'h0
`define PLC_RST_ROW 3'h0
`define PLC_RST_RDATA 32'h0000_0000

`endif

// ==== verilog/plc_pkg.sv ====
// Types of the custom logic cell: input sources and input qualifiers
package plc_pkg;

    typedef enum logic [4:0] {
        SRC_ZERO,
        SRC_LINE0,
        SRC_LINE1,
        SRC_LINE2,
        SRC_LINE3,
        SRC_USER0,
        SRC_USER1,
        SRC_USER2,
        SRC_USER3,
        SRC_CTR0_START,
        SRC_CTR1_START,
        SRC_CTR0_END,
        SRC_CTR1_END,
        SRC_CELL0,
        SRC_CELL1,
        SRC_EXPOSURE_START,
        SRC_EXPOSURE_END,
        SRC_AWAITING_FRAME_TRIGGER,
        SRC_CAPTURE_IN_PROGRESS
    } plc_src_e;

    typedef enum logic [2:0] {
        QUAL_LEVEL_LOW,
        QUAL_LEVEL_HIGH,
        QUAL_FALLING_EDGE,
        QUAL_RISING_EDGE,
        QUAL_ANY_EDGE
    } plc_qual_e;

endpackage : plc_pkg

// ==== verilog/plc_cell.sv ====
// Two programmable lookup-table cells with registered outputs
//
// What this block does
// - Each cell has two lookup tables feeding one output flip-flop.
// - Value table drives flip-flop data, enable table drives its enable.
// - Each table has three one-bit inputs and eight truth bits.
// - Value and enable tables of a cell share one input selection set.
// - Each input has a source select and a level or edge qualifier.
// - Truth bits written one row at a time or as one whole word.
// - Word bit n is row input2*4 + input1*2 + input0.
// - Output holds while enable is false, loads value when true.
// - Two cells, a cell selector, and both outputs usable as sources.
// - Qualifiers: level low, level high, falling, rising, any edge.
// - Sources: zero, lines, user outputs, counters, cells, exposure, etc.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "plc_defines.svh"

module plc_cell #(
    parameter int unsigned ADDR_W = `PLC_ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [`PLC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`PLC_DATA_W-1:0] rdata_o,
    input wire logic [3:0] line_i,
    input wire logic [3:0] user_out_i,
    input wire logic [1:0] counter_start_i,
    input wire logic [1:0] counter_end_i,
    input wire logic exposure_start_i,
    input wire logic exposure_end_i,
    input wire logic awaiting_frame_trigger_i,
    input wire logic capture_in_progress_i,
    output logic custom_cell_0_out_o,
    output logic custom_cell_1_out_o
);

    localparam int NC = `PLC_CELLS;
    localparam int NI = `PLC_TABLE_INPUTS;
    localparam int NS = `PLC_SRC_COUNT;

    // Qualified input bit from the current and previous source level
    function automatic logic plc_qualify(
        input logic cur,
        input logic prev,
        input logic [`PLC_QUAL_W-1:0] mode
    );
        logic res;
        res = 1'b0;
        unique case (plc_pkg::plc_qual_e'(mode))
            plc_pkg::QUAL_LEVEL_LOW: res = ~cur;
            plc_pkg::QUAL_LEVEL_HIGH: res = cur;
            plc_pkg::QUAL_FALLING_EDGE: res = prev & ~cur;
            plc_pkg::QUAL_RISING_EDGE: res = cur & ~prev;
            plc_pkg::QUAL_ANY_EDGE: res = cur ^ prev;
            // Codes 5 to 7 are refused on write; read as false
            default: res = 1'b0;
        endcase
        return res;
    endfunction : plc_qualify

    logic [NC-1:0][NI-1:0][`PLC_SRC_W-1:0] src_reg, src_next;
    logic [NC-1:0][NI-1:0][`PLC_QUAL_W-1:0] qual_reg, qual_next;
    logic [NC-1:0][`PLC_TABLES-1:0][`PLC_TABLE_ROWS-1:0] lut_reg, lut_next;
    logic [NC-1:0] out_reg, out_next;
    logic [NS-1:0] prev_reg, prev_next;
    logic cell_sel_reg, cell_sel_next;
    logic table_sel_reg, table_sel_next;
    logic [1:0] input_sel_reg, input_sel_next;
    logic [2:0] row_reg, row_next;
    logic [`PLC_DATA_W-1:0] rdata_reg, rdata_next;

    logic [NS-1:0] src_vec;
    logic [NC-1:0][NI-1:0] in_val;
    logic input_ok;

    // Source vector in source-code order; cell outputs feed back
    assign src_vec = {
        capture_in_progress_i,
        awaiting_frame_trigger_i,
        exposure_end_i,
        exposure_start_i,
        out_reg[1],
        out_reg[0],
        counter_end_i[1],
        counter_end_i[0],
        counter_start_i[1],
        counter_start_i[0],
        user_out_i,
        line_i,
        1'b0
    };

    assign input_ok = (input_sel_reg < 2'(NI));

    // Qualified table inputs, shared by both tables of a cell
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            for (int i = 0; i < NI; i++) begin
                in_val[c][i] = plc_qualify(src_vec[src_reg[c][i]],
                    prev_reg[src_reg[c][i]], qual_reg[c][i]);
            end
        end
    end

    always_comb begin
        src_next = src_reg;
        qual_next = qual_reg;
        lut_next = lut_reg;
        cell_sel_next = cell_sel_reg;
        table_sel_next = table_sel_reg;
        input_sel_next = input_sel_reg;
        row_next = row_reg;
        prev_next = src_vec;
        rdata_next = `PLC_RST_RDATA;

        // Cell evaluation: row index is {input2, input1, input0}
        for (int c = 0; c < NC; c++) begin
            if (lut_reg[c][`PLC_TABLE_ENABLE][in_val[c]]) begin
                out_next[c] = lut_reg[c][`PLC_TABLE_VALUE][in_val[c]];
            end else begin
                out_next[c] = out_reg[c];
            end
        end

        if (wr_i) begin
            case (addr_i)
                `PLC_OFS_CELL_SELECT: begin
                    cell_sel_next = wdata_i[0];
                end
                `PLC_OFS_TABLE_SELECT: begin
                    table_sel_next = wdata_i[0];
                end
                `PLC_OFS_INPUT_SELECT: begin
                    input_sel_next = wdata_i[1:0];
                end
                `PLC_OFS_INPUT_SOURCE: begin
                    // Out-of-range codes and unused input slot ignored
                    if (input_ok && wdata_i < `PLC_DATA_W'(NS)) begin
                        src_next[cell_sel_reg][input_sel_reg] =
                            wdata_i[`PLC_SRC_W-1:0];
                    end
                end
                `PLC_OFS_INPUT_QUALIFIER: begin
                    if (input_ok &&
                        wdata_i < `PLC_DATA_W'(`PLC_QUAL_COUNT)) begin
                        qual_next[cell_sel_reg][input_sel_reg] =
                            wdata_i[`PLC_QUAL_W-1:0];
                    end
                end
                `PLC_OFS_TABLE_WORD: begin
                    lut_next[cell_sel_reg][table_sel_reg] =
                        wdata_i[7:0];
                end
                `PLC_OFS_ROW_INDEX: begin
                    row_next = wdata_i[2:0];
                end
                `PLC_OFS_ROW_BIT: begin
                    lut_next[cell_sel_reg][table_sel_reg][row_reg] =
                        wdata_i[0];
                end
                default: begin
                end
            endcase
        end

        // Read data stands only in the cycle after the strobe
        if (rd_i) begin
            case (addr_i)
                `PLC_OFS_CELL_SELECT: begin
                    rdata_next[0] = cell_sel_reg;
                end
                `PLC_OFS_TABLE_SELECT: begin
                    rdata_next[0] = table_sel_reg;
                end
                `PLC_OFS_INPUT_SELECT: begin
                    rdata_next[1:0] = input_sel_reg;
                end
                `PLC_OFS_INPUT_SOURCE: begin
                    if (input_ok) begin
                        rdata_next[`PLC_SRC_W-1:0] =
                            src_reg[cell_sel_reg][input_sel_reg];
                    end
                end
                `PLC_OFS_INPUT_QUALIFIER: begin
                    if (input_ok) begin
                        rdata_next[`PLC_QUAL_W-1:0] =
                            qual_reg[cell_sel_reg][input_sel_reg];
                    end
                end
                `PLC_OFS_TABLE_WORD: begin
                    rdata_next[7:0] = lut_reg[cell_sel_reg][table_sel_reg];
                end
                `PLC_OFS_ROW_INDEX: begin
                    rdata_next[2:0] = row_reg;
                end
                `PLC_OFS_ROW_BIT: begin
                    rdata_next[0] =
                        lut_reg[cell_sel_reg][table_sel_reg][row_reg];
                end
                `PLC_OFS_STATUS: begin
                    rdata_next[1:0] = out_reg;
                    rdata_next[4:2] = in_val[0];
                    rdata_next[7:5] = in_val[1];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NC; c++) begin
                for (int i = 0; i < NI; i++) begin
                    src_reg[c][i] <= plc_pkg::SRC_ZERO;
                    qual_reg[c][i] <= plc_pkg::QUAL_LEVEL_HIGH;
                end
                for (int t = 0; t < `PLC_TABLES; t++) begin
                    lut_reg[c][t] <= `PLC_RST_TABLE;
                end
                out_reg[c] <= `PLC_RST_OUT;
            end
            prev_reg <= '0;
            cell_sel_reg <= `PLC_RST_SEL;
            table_sel_reg <= `PLC_RST_SEL;
            input_sel_reg <= `PLC_RST_INPUT_SEL;
            row_reg <= `PLC_RST_ROW;
            rdata_reg <= `PLC_RST_RDATA;
        end else begin
            src_reg <= src_next;
            qual_reg <= qual_next;
            lut_reg <= lut_next;
            out_reg <= out_next;
            prev_reg <= prev_next;
            cell_sel_reg <= cell_sel_next;
            table_sel_reg <= table_sel_next;
            input_sel_reg <= input_sel_next;
            row_reg <= row_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign custom_cell_0_out_o = out_reg[0];
    assign custom_cell_1_out_o = out_reg[1];

endmodule : plc_cell

// ==== testbench/plc_far_end.sv ====
// Far-side model of the camera signals feeding the logic cells
`timescale 1ns/1ps
module plc_far_end (
    input wire logic [15:0] drive_i,
    output logic [3:0] line_o,
    output logic [3:0] user_o,
    output logic [1:0] start_o,
    output logic [1:0] end_o,
    output logic exp_start_o,
    output logic exp_end_o,
    output logic awaiting_o,
    output logic capture_o
);
    // Levels held between changes, bit order follows source codes
    assign {capture_o, awaiting_o, exp_end_o, exp_start_o} = drive_i[15:12];
    assign {end_o, start_o, user_o, line_o} = drive_i[11:0];
endmodule : plc_far_end

// ==== testbench/plc_cell_chk.sv ====
// Port assertions of the custom logic cells
`timescale 1ns/1ps
`include "plc_defines.svh"
module plc_cell_chk #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic custom_cell_0_out_o,
    input wire logic custom_cell_1_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    chk_reset_clear: assert property (disable iff (1'b0) rst_i |=>
        !custom_cell_0_out_o && !custom_cell_1_out_o && rdata_o == 32'h0)
        else $error("reset did not clear outputs");
    chk_unmapped_zero: assert property (rd_i && addr_i > 8'h20 |=>
        rdata_o == 32'h0) else $error("unmapped read not zero");
    chk_status_outs: assert property (rd_i && addr_i == 8'h20 |=>
        rdata_o[0] == $past(custom_cell_0_out_o) &&
        rdata_o[1] == $past(custom_cell_1_out_o) &&
        rdata_o[31:8] == 24'h0) else $error("status bits wrong");
    chk_word_width: assert property (rd_i && addr_i == 8'h14 |=>
        rdata_o[31:8] == 24'h0) else $error("table word too wide");
    chk_source_range: assert property (rd_i && addr_i == 8'h0c |=>
        rdata_o <= 32'h12) else $error("source code out of range");
    chk_qual_range: assert property (rd_i && addr_i == 8'h10 |=>
        rdata_o <= 32'h4) else $error("qualifier out of range");
    chk_row_width: assert property (rd_i && addr_i == 8'h18 ##1 1'b1
        |-> rdata_o[31:3] == 29'h0) else $error("row index too wide");
    chk_sel_width: assert property (rd_i && addr_i == 8'h00 |=>
        rdata_o[31:1] == 31'h0) else $error("cell select too wide");
endmodule : plc_cell_chk
bind plc_cell plc_cell_chk #(.ADDR_W(ADDR_W)) plc_cell_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .custom_cell_0_out_o(custom_cell_0_out_o),
    .custom_cell_1_out_o(custom_cell_1_out_o));

// ==== testbench/plc_cell_test.sv ====
// Self-checking bench of the custom logic cells
`timescale 1ns/1ps
`include "plc_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    bad_count++; $display("[ERR] %0t %h %h", $time, a, e); end end
module plc_cell_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] drv = 16'h0;
    logic [3:0] ln, us;
    logic [1:0] cs, ce;
    logic xs, xe, aw, cp, c0, c1;
    int bad_count = 0;
    int check_count = 0;
    // Four samples per qualifier: rise, hold, fall, hold
    logic [3:0] qexp [5] = '{4'h3, 4'hc, 4'h2, 4'h8, 4'ha};
    always #10 clk_i = ~clk_i;
    plc_cell plc_cell_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .line_i(ln), .user_out_i(us), .counter_start_i(cs),
        .counter_end_i(ce), .exposure_start_i(xs), .exposure_end_i(xe),
        .awaiting_frame_trigger_i(aw), .capture_in_progress_i(cp),
        .custom_cell_0_out_o(c0), .custom_cell_1_out_o(c1));
    plc_far_end plc_far_end_inst (.drive_i(drv), .line_o(ln), .user_o(us),
        .start_o(cs), .end_o(ce), .exp_start_o(xs), .exp_end_o(xe),
        .awaiting_o(aw), .capture_o(cp));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : rd_reg
    task automatic out_at(input logic [15:0] d, input logic [1:0] e);
        @(posedge clk_i);
        drv <= d;
        @(posedge clk_i);
        #1 `CHK({c1, c0}, e)
    endtask : out_at
    task automatic cfg_in(input logic [31:0] c, i, s, q);
        wr_reg(`PLC_OFS_CELL_SELECT, c);
        wr_reg(`PLC_OFS_INPUT_SELECT, i);
        wr_reg(`PLC_OFS_INPUT_SOURCE, s);
        wr_reg(`PLC_OFS_INPUT_QUALIFIER, q);
    endtask : cfg_in
    task automatic tables(input logic [31:0] v, en);
        wr_reg(`PLC_OFS_TABLE_SELECT, 32'h1);
        wr_reg(`PLC_OFS_TABLE_WORD, en);
        wr_reg(`PLC_OFS_TABLE_SELECT, 32'h0);
        wr_reg(`PLC_OFS_TABLE_WORD, v);
    endtask : tables
    task automatic summarize;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd_reg(8'(a * 4), (a == 4) ? 32'h1 : 32'h0);
        end
        wr_reg(8'h24, 32'hff);
        rd_reg(8'h24, 32'h0);
        tables(32'haa, 32'hff);
        for (int s = 1; s < 19; s++) begin
            if (s == 13 || s == 14) continue;
            cfg_in(32'h0, 32'h0, 32'(s), 32'h1);
            out_at(16'h1 << (s > 12 ? s - 3 : s - 1), 2'h1);
            out_at(16'h0, 2'h0);
        end
        for (int q = 0; q < 5; q++) begin
            cfg_in(32'h0, 32'h0, 32'h1, 32'(q));
            for (int k = 0; k < 4; k++) begin
                out_at(16'(k < 2), 2'(qexp[q][3 - k]));
            end
        end
        cfg_in(32'h0, 32'h0, 32'h1, 32'h1);
        cfg_in(32'h0, 32'h1, 32'h2, 32'h1);
        cfg_in(32'h0, 32'h2, 32'h3, 32'h1);
        tables(32'hc0, 32'hff);
        for (int r = 0; r < 8; r++) begin
            out_at(16'(r), 2'(r > 5));
        end
        wr_reg(`PLC_OFS_ROW_INDEX, 32'h1);
        wr_reg(`PLC_OFS_ROW_BIT, 32'h1);
        rd_reg(`PLC_OFS_TABLE_WORD, 32'hc2);
        rd_reg(`PLC_OFS_ROW_BIT, 32'h1);
        out_at(16'h1, 2'h1);
        wr_reg(`PLC_OFS_TABLE_SELECT, 32'h1);
        wr_reg(`PLC_OFS_TABLE_WORD, 32'h0);
        out_at(16'h0, 2'h1);
        wr_reg(`PLC_OFS_ROW_INDEX, 32'h0);
        wr_reg(`PLC_OFS_ROW_BIT, 32'h1);
        out_at(16'h0, 2'h0);
        out_at(16'h6, 2'h0);
        rd_reg(`PLC_OFS_INPUT_SOURCE, 32'h3);
        wr_reg(`PLC_OFS_INPUT_SOURCE, 32'h13);
        wr_reg(`PLC_OFS_INPUT_QUALIFIER, 32'h5);
        rd_reg(`PLC_OFS_INPUT_SOURCE, 32'h3);
        rd_reg(`PLC_OFS_INPUT_QUALIFIER, 32'h1);
        cfg_in(32'h1, 32'h0, 32'hd, 32'h1);
        tables(32'haa, 32'hff);
        wr_reg(`PLC_OFS_CELL_SELECT, 32'h0);
        wr_reg(`PLC_OFS_TABLE_WORD, 32'hff);
        out_at(16'h0, 2'h1);
        out_at(16'h0, 2'h3);
        rd_reg(`PLC_OFS_STATUS, 32'h23);
        wr_reg(`PLC_OFS_INPUT_SELECT, 32'h3);
        wr_reg(`PLC_OFS_INPUT_SOURCE, 32'he);
        rd_reg(`PLC_OFS_INPUT_SOURCE, 32'h0);
        wr_reg(`PLC_OFS_INPUT_SELECT, 32'h1);
        wr_reg(`PLC_OFS_INPUT_SOURCE, 32'he);
        rd_reg(`PLC_OFS_INPUT_SOURCE, 32'he);
        rd_reg(`PLC_OFS_STATUS, 32'h2b);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd_reg(`PLC_OFS_TABLE_WORD, 32'h0);
        out_at(16'h7, 2'h0);
        summarize();
    end
endmodule : plc_cell_test
